// ### can_engine_model.sv
/* engine stand-in: feeds received frames, takes and ends tx frames.
   assumes: bench sets lag and fails by hierarchy. */
`timescale 1ns/1ps
module can_engine_model
   import can_msg_pkg::*;
(
   // clock
   input  wire logic       pclk,
   // receive side
   output logic            rx_hdr_valid, rx_done, rx_abort,
   output rx_hdr_t         rx_hdr,
   output logic [63:0]     rx_data,
   // transmit side
   input  wire logic       tx_valid,
   input  wire tx_frame_t  tx_frame,
   output logic            tx_ready, tx_ok, tx_fail
);
   // ==========
   int        lag, fails, ends;  // ready delay, forced failures, ended frames
   tx_frame_t q[$];              // frames taken, in order
   initial
   begin
      {rx_hdr_valid, rx_done, rx_abort, tx_ready, tx_ok, tx_fail} = '0;
      rx_hdr = '1;
      rx_data = '1;
      forever
      begin
         @(posedge pclk);
         if (tx_valid === 1'b1)
         begin
            repeat (lag) @(posedge pclk);
            tx_ready <= 1'b1;
            @(posedge pclk);
            q.push_back(tx_frame);
            tx_ready <= 1'b0;
            repeat (20) @(posedge pclk);  // frame on the wire
            tx_ok <= (fails == 0);
            tx_fail <= (fails != 0);  // forced loss
            if (fails != 0) fails--;
            @(posedge pclk);
            {tx_ok, tx_fail} <= 2'b00;
            ends++;
         end
      end
   end
   // one frame: header, scan room, data
   task automatic rx_frame(input rx_hdr_t h, input logic [63:0] d);
      @(posedge pclk);
      rx_hdr <= h;
      rx_hdr_valid <= 1'b1;
      @(posedge pclk);
      rx_hdr_valid <= 1'b0;
      rx_hdr <= ~h;  // header gone
      repeat (40) @(posedge pclk);
      rx_data <= d;
      rx_done <= 1'b1;
      @(posedge pclk);
      rx_done <= 1'b0;
      rx_data <= ~d;
   endtask
endmodule // can_engine_model

// ### can_message_object_handler.sv
/*
 * message object handler: object store, cpu interface set over apb,
 * acceptance scan of received frames, priority transmit selection.
 * assumes: protocol engine on pclk, pulses one event per cycle, never
 * rx_done and tx_ok together; apb master per amba apb.
 */
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "can_msg_cfg.svh"
module can_message_object_handler
   import can_msg_pkg::*;
#(
   parameter int NUM_OBJ = 32  // objects in the store
)(
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // receive side of protocol engine
   input  wire logic        rx_hdr_valid,
   input  wire rx_hdr_t     rx_hdr,
   input  wire logic        rx_done,
   input  wire logic [63:0] rx_data,
   input  wire logic        rx_abort,
   // transmit side of protocol engine
   input  wire logic        tx_ready,
   output logic             tx_valid,
   output tx_frame_t        tx_frame,
   input  wire logic        tx_ok,
   input  wire logic        tx_fail
);
   // ==================================================
   // storage and interface set
   obj_t        objects [NUM_OBJ];  // the object store
   logic [7:0]  cmd_mask;           // command_mask
   logic [5:0]  cmd_num;            // object number of command_request
   logic        cmd_pending;        // command waiting for the store
   obj_t        ifr;                // interface staging copy
   scan_state_t scan_state;         // acceptance scan state
   rx_hdr_t     hdr;                // latched incoming header
   logic [4:0]  scan_idx;           // object under compare
   logic [4:0]  hit_idx;            // matching object
   logic        tx_active;          // frame handed or on the bus
   logic [4:0]  tx_idx;             // object being sent
   logic        apb_wr;             // write takes effect
   logic        apb_setup;          // setup phase of any transfer
   logic        rx_commit;          // frame complete on a match
   logic        cpu_go;             // command runs this cycle
   logic        tx_pick;            // a pending object exists
   logic [4:0]  tx_sel;             // highest priority pending
   logic [4:0]  cmd_idx;            // store index of command
   // ==================================================
   // helpers
   // acceptance compare of one object against a header
   function automatic logic obj_match(obj_t o, rx_hdr_t h);
      logic [28:0] care;
      logic        care_x;
      logic        care_d;
      care   = o.use_acceptance_mask ? o.id_mask_bits : '1;
      care_x = o.use_acceptance_mask ? o.mask_extended_flag : 1'b1;
      care_d = o.use_acceptance_mask ? o.mask_direction : 1'b1;
      if (!o.xtd)
      begin
         care[`STD_ID_LSB-1:0] = '0;
      end
      obj_match = o.object_valid && ((o.id ^ h.id) & care) == '0
                  && (!care_x || o.xtd == h.xtd)
                  && (!care_d || o.direction_transmit == h.rtr);
   endfunction
   // address map check
   function automatic logic addr_ok(logic [7:0] a);
      addr_ok = (a[1:0] == 2'b00) && (a <= `OFS_HANDLER_STATUS);
   endfunction
   // ==================================================
   // apb handshake and event qualifiers
   assign pready    = 1'b1;  // zero wait states
   assign pslverr   = psel && penable && !addr_ok(paddr);
   assign apb_wr    = ce && psel && penable && pwrite && addr_ok(paddr);
   assign apb_setup = ce && psel && !penable;
   assign rx_commit = ce && scan_state == SCAN_MATCH && rx_done;
   // store access yields to frame events
   assign cpu_go    = ce && cmd_pending && !rx_commit && !(tx_active && (tx_ok || tx_fail));
   assign cmd_idx   = 5'(cmd_num - 6'h01);
   // lowest numbered valid object with a request wins
   always_comb
   begin
      tx_pick = 1'b0;
      tx_sel  = '0;
      for (int i = NUM_OBJ - 1; i >= 0; i--)
      begin
         if (objects[i].object_valid && objects[i].transmit_request)
         begin
            tx_pick = 1'b1;
            tx_sel  = 5'(i);
         end
      end
   end
   // ==================================================
   // apb read data, captured in the setup phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= '0;
      end
      else if (apb_setup)
      begin
         if (paddr == `OFS_COMMAND_REQUEST)
            prdata <= {16'h0000, cmd_pending, 9'h000, cmd_num};
         else if (paddr == `OFS_COMMAND_MASK)
            prdata <= {24'h000000, cmd_mask};
         else if (paddr == `OFS_MASK_WORDS)
            prdata <= {ifr.mask_extended_flag, ifr.mask_direction, 1'b0, ifr.id_mask_bits};
         else if (paddr == `OFS_ARBITRATION_WORD_ONE)
            prdata <= {3'h0, ifr.id};
         else if (paddr == `OFS_ARBITRATION_WORD_TWO)
            prdata <= {29'h0, ifr.object_valid, ifr.xtd, ifr.direction_transmit};
         else if (paddr == `OFS_OBJECT_CONTROL_WORD)
            prdata <= {16'h0000, ifr.new_data_flag, ifr.message_lost_flag, ifr.irq_pending,
                       ifr.use_acceptance_mask, ifr.transmit_irq_enable,
                       ifr.receive_irq_enable, ifr.remote_enable, ifr.transmit_request,
                       ifr.end_of_block, 3'h0, ifr.dlc};
         else if (paddr == `OFS_DATA_A_WORDS)
            prdata <= ifr.data[31:0];
         else if (paddr == `OFS_DATA_B_WORDS)
            prdata <= ifr.data[63:32];
         else if (paddr == `OFS_HANDLER_STATUS)
            prdata <= {25'h0, tx_active, tx_idx, scan_state != SCAN_IDLE};
         else
            prdata <= '0;  // unmapped reads zero
      end
   end
   // ==================================================
   // command registers; a new request replaces a waiting one
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_mask    <= '0;
         cmd_num     <= '0;
         cmd_pending <= 1'b0;
      end
      else
      begin
         if (cpu_go)
            cmd_pending <= 1'b0;
         if (apb_wr && paddr == `OFS_COMMAND_MASK)
            cmd_mask <= pwdata[7:0];
         if (apb_wr && paddr == `OFS_COMMAND_REQUEST)
         begin
            cmd_num     <= pwdata[5:0];
            cmd_pending <= pwdata[5:0] != 6'h00 && pwdata[5:0] <= 6'(NUM_OBJ);
         end
      end
   end
   // ==================================================
   // interface staging set: cpu writes, read commands fill it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ifr <= '0;
      end
      else if (cpu_go && !cmd_mask[`CMD_WRITE_DIRECTION])
      begin
         // fields not selected keep their staged value
         if (cmd_mask[`CMD_MASK])
         begin
            ifr.id_mask_bits       <= objects[cmd_idx].id_mask_bits;
            ifr.mask_extended_flag <= objects[cmd_idx].mask_extended_flag;
            ifr.mask_direction     <= objects[cmd_idx].mask_direction;
         end
         if (cmd_mask[`CMD_ARB])
         begin
            ifr.id                 <= objects[cmd_idx].id;
            ifr.xtd                <= objects[cmd_idx].xtd;
            ifr.direction_transmit <= objects[cmd_idx].direction_transmit;
            ifr.object_valid       <= objects[cmd_idx].object_valid;
         end
         if (cmd_mask[`CMD_CONTROL])
         begin
            ifr.new_data_flag       <= objects[cmd_idx].new_data_flag;
            ifr.message_lost_flag   <= objects[cmd_idx].message_lost_flag;
            ifr.irq_pending         <= objects[cmd_idx].irq_pending;
            ifr.use_acceptance_mask <= objects[cmd_idx].use_acceptance_mask;
            ifr.transmit_irq_enable <= objects[cmd_idx].transmit_irq_enable;
            ifr.receive_irq_enable  <= objects[cmd_idx].receive_irq_enable;
            ifr.remote_enable       <= objects[cmd_idx].remote_enable;
            ifr.transmit_request    <= objects[cmd_idx].transmit_request;
            ifr.end_of_block        <= objects[cmd_idx].end_of_block;
            ifr.dlc                 <= objects[cmd_idx].dlc;
         end
         if (cmd_mask[`CMD_DATA_LOW])
            ifr.data[31:0] <= objects[cmd_idx].data[31:0];
         if (cmd_mask[`CMD_DATA_HIGH])
            ifr.data[63:32] <= objects[cmd_idx].data[63:32];
      end
      else if (apb_wr)
      begin
         if (paddr == `OFS_MASK_WORDS)
            {ifr.mask_extended_flag, ifr.mask_direction, ifr.id_mask_bits}
               <= {pwdata[31:30], pwdata[28:0]};
         else if (paddr == `OFS_ARBITRATION_WORD_ONE)
            ifr.id <= pwdata[28:0];
         else if (paddr == `OFS_ARBITRATION_WORD_TWO)
            {ifr.object_valid, ifr.xtd, ifr.direction_transmit} <= pwdata[2:0];
         else if (paddr == `OFS_OBJECT_CONTROL_WORD)
            {ifr.new_data_flag, ifr.message_lost_flag, ifr.irq_pending,
             ifr.use_acceptance_mask, ifr.transmit_irq_enable, ifr.receive_irq_enable,
             ifr.remote_enable, ifr.transmit_request, ifr.end_of_block, ifr.dlc}
               <= {pwdata[15:7], pwdata[3:0]};
         else if (paddr == `OFS_DATA_A_WORDS)
            ifr.data[31:0] <= pwdata;
         else if (paddr == `OFS_DATA_B_WORDS)
            ifr.data[63:32] <= pwdata;
      end
   end
   // ==================================================
   // acceptance scan, one object per cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scan_state <= SCAN_IDLE;
         hdr        <= '0;
         scan_idx   <= '0;
         hit_idx    <= '0;
      end
      else if (ce)
      begin
         case (scan_state)
            SCAN_IDLE:
            begin
               if (rx_hdr_valid)
               begin
                  hdr        <= rx_hdr;
                  scan_idx   <= '0;
                  scan_state <= SCAN_WALK;
               end
            end
            SCAN_WALK:
            begin
               if (rx_abort)
                  scan_state <= SCAN_IDLE;
               else if (obj_match(objects[scan_idx], hdr))
               begin
                  hit_idx    <= scan_idx;
                  scan_state <= SCAN_MATCH;
               end
               else if (scan_idx == 5'(NUM_OBJ - 1))
                  scan_state <= SCAN_IDLE;
               else
                  scan_idx <= scan_idx + 5'h01;
            end
            SCAN_MATCH:
            begin
               // frame lands only when fully received
               if (rx_done || rx_abort)
                  scan_state <= SCAN_IDLE;
            end
            default:
               scan_state <= SCAN_IDLE;
         endcase
      end
   end
   // ==================================================
   // transmit hand-off, after store events
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_active <= 1'b0;
         tx_valid  <= 1'b0;
         tx_idx    <= '0;
         tx_frame  <= '0;
      end
      else if (ce)
      begin
         if (tx_valid && tx_ready)
            tx_valid <= 1'b0;
         if (tx_active && (tx_ok || tx_fail))
            tx_active <= 1'b0;
         else if (!tx_active && tx_pick && !cpu_go && !rx_commit)
         begin
            tx_active       <= 1'b1;
            tx_valid        <= 1'b1;
            tx_idx          <= tx_sel;
            tx_frame.id     <= objects[tx_sel].id;
            tx_frame.xtd    <= objects[tx_sel].xtd;
            // receive object with a request sends a remote frame
            tx_frame.rtr    <= !objects[tx_sel].direction_transmit;
            tx_frame.dlc    <= objects[tx_sel].dlc;
            tx_frame.data   <= objects[tx_sel].data;
         end
      end
   end
   // ==================================================
   // object store updates, one source per cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < NUM_OBJ; i++)
            objects[i] <= '0;
      end
      else if (rx_commit && !hdr.rtr)
      begin
         // data frame into a receive object
         objects[hit_idx].data              <= rx_data;
         objects[hit_idx].dlc               <= hdr.dlc;
         objects[hit_idx].xtd               <= hdr.xtd;
         objects[hit_idx].id                <= hdr.xtd ? hdr.id
                                               : {hdr.id[28:`STD_ID_LSB], 18'h00000};
         objects[hit_idx].new_data_flag     <= 1'b1;
         if (objects[hit_idx].new_data_flag)
            objects[hit_idx].message_lost_flag <= 1'b1;
         if (objects[hit_idx].receive_irq_enable)
            objects[hit_idx].irq_pending <= 1'b1;
         objects[hit_idx].transmit_request  <= 1'b0;
      end
      else if (rx_commit)
      begin
         // remote frame into a transmit object
         if (objects[hit_idx].remote_enable)
            objects[hit_idx].transmit_request <= 1'b1;
         else if (objects[hit_idx].use_acceptance_mask)
         begin
            objects[hit_idx].transmit_request <= 1'b0;
            objects[hit_idx].id               <= hdr.id;
            objects[hit_idx].xtd              <= hdr.xtd;
            objects[hit_idx].dlc              <= hdr.dlc;
            objects[hit_idx].new_data_flag    <= 1'b1;
         end
         // remote disabled and unmasked: nothing changes
      end
      else if (ce && tx_active && tx_ok)
      begin
         if (!objects[tx_idx].new_data_flag)
            objects[tx_idx].transmit_request <= 1'b0;
         if (objects[tx_idx].transmit_irq_enable)
            objects[tx_idx].irq_pending <= 1'b1;
      end
      else if (cpu_go && cmd_mask[`CMD_WRITE_DIRECTION])
      begin
         // writes need no prior invalidation of the object
         if (cmd_mask[`CMD_MASK])
         begin
            objects[cmd_idx].id_mask_bits       <= ifr.id_mask_bits;
            objects[cmd_idx].mask_extended_flag <= ifr.mask_extended_flag;
            objects[cmd_idx].mask_direction     <= ifr.mask_direction;
         end
         if (cmd_mask[`CMD_ARB])
         begin
            objects[cmd_idx].id                 <= ifr.id;
            objects[cmd_idx].xtd                <= ifr.xtd;
            objects[cmd_idx].direction_transmit <= ifr.direction_transmit;
            objects[cmd_idx].object_valid       <= ifr.object_valid;
         end
         if (cmd_mask[`CMD_CONTROL])
         begin
            objects[cmd_idx].new_data_flag       <= ifr.new_data_flag;
            objects[cmd_idx].message_lost_flag   <= ifr.message_lost_flag;
            objects[cmd_idx].irq_pending         <= ifr.irq_pending;
            objects[cmd_idx].use_acceptance_mask <= ifr.use_acceptance_mask;
            objects[cmd_idx].transmit_irq_enable <= ifr.transmit_irq_enable;
            objects[cmd_idx].receive_irq_enable  <= ifr.receive_irq_enable;
            objects[cmd_idx].remote_enable       <= ifr.remote_enable;
            objects[cmd_idx].transmit_request    <= ifr.transmit_request;
            objects[cmd_idx].end_of_block        <= ifr.end_of_block;
            objects[cmd_idx].dlc                 <= ifr.dlc;
         end
         if (cmd_mask[`CMD_CLEAR_IRQ])
            objects[cmd_idx].irq_pending <= 1'b0;
         if (cmd_mask[`CMD_NEW_DATA])
         begin
            objects[cmd_idx].new_data_flag    <= 1'b1;
            objects[cmd_idx].transmit_request <= 1'b1;
         end
         if (cmd_mask[`CMD_DATA_LOW])
            objects[cmd_idx].data[31:0] <= ifr.data[31:0];
         if (cmd_mask[`CMD_DATA_HIGH])
            objects[cmd_idx].data[63:32] <= ifr.data[63:32];
      end
      else if (cpu_go)
      begin
         // read command acknowledges the object
         if (cmd_mask[`CMD_CLEAR_IRQ])
            objects[cmd_idx].irq_pending <= 1'b0;
         if (cmd_mask[`CMD_NEW_DATA])
            objects[cmd_idx].new_data_flag <= 1'b0;
      end
      else if (ce && !tx_active && tx_pick)
      begin
         objects[tx_sel].new_data_flag <= 1'b0;
      end
   end
endmodule // can_message_object_handler

// ### can_message_object_handler_bench.sv
/* self-checking bench: apb master, engine model, expected values.
   assumes: the other files compiled before it. */
`timescale 1ns/1ps
`include "can_msg_cfg.svh"
module can_message_object_handler_bench import can_msg_pkg::*; ;
   // ==========
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
   logic        rx_hdr_valid, rx_done, rx_abort, tx_ready, tx_valid, tx_ok, tx_fail;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [63:0] rx_data;
   rx_hdr_t     rx_hdr;
   tx_frame_t   tx_frame;
   logic [5:0]  rnd;
   logic [31:0] dat [32];
   int          miscompares, num_checks, cycles;
   int          pri [3] = '{9, 2, 5};
   int          ord [4] = '{9, 2, 5, 9};
   can_message_object_handler #(.NUM_OBJ(32)) can_message_object_handler_i (.*);
   can_engine_model can_engine_model_i (.*);
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk)
      if (++cycles == 20000)
      begin
         miscompares++;
         end_of_test();
      end
   // standard ids, object 2 above 5 in value
   function automatic logic [28:0] idk(input int k);
      return {rnd, ~k[4:0], 18'h0};
   endfunction
   task automatic chk(input logic [31:0] g, x);
      num_checks++;
      if (g !== x)
      begin
         $display("[FAIL] %0t got %h exp %h", $time, g, x);
         miscompares++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic rdk(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(rd, x);
   endtask
   task automatic cmd(input logic [7:0] m, input int n);
      apb(1'b1, `OFS_COMMAND_MASK, {24'h0, m});
      apb(1'b1, `OFS_COMMAND_REQUEST, {26'h0, n[5:0]});
      do apb(1'b0, `OFS_COMMAND_REQUEST, 32'h0); while (rd[`BUSY_BIT] !== 1'b0);
   endtask
   task automatic ctl(input int n, input logic [31:0] x);
      cmd(8'h7f, n);
      rdk(`OFS_OBJECT_CONTROL_WORD, x);
   endtask
   task automatic cfg(input int n, input logic [31:0] msk, input logic dir, input logic [31:0] c);
      apb(1'b1, `OFS_MASK_WORDS, msk);
      apb(1'b1, `OFS_ARBITRATION_WORD_ONE, {3'h0, idk(n)});
      apb(1'b1, `OFS_ARBITRATION_WORD_TWO, {29'h0, 2'b10, dir});
      apb(1'b1, `OFS_OBJECT_CONTROL_WORD, c);
      apb(1'b1, `OFS_DATA_A_WORDS, dat[n]);
      apb(1'b1, `OFS_DATA_B_WORDS, ~dat[n]);
      cmd(8'hf3, n);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      {ce, psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      void'($urandom(4));
      rnd = 6'($urandom_range(63));
      foreach (dat[i]) dat[i] = $urandom;
      repeat (2) @(posedge pclk);
      {presetn, ce} <= 2'b11;
      apb(1'b0, 8'h24, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      // priority, retry: 9 fails once, 2 and 5 wait
      can_engine_model_i.lag = 100;
      can_engine_model_i.fails = 1;
      foreach (pri[i]) cfg(pri[i], 32'h0, 1'b1, 32'h888);
      foreach (pri[i])
      begin
         dat[pri[i]] = $urandom;
         apb(1'b1, `OFS_DATA_A_WORDS, dat[pri[i]]);
         apb(1'b1, `OFS_DATA_B_WORDS, ~dat[pri[i]]);
         cmd(8'h87, pri[i]);
      end
      ce <= 1'b0;
      repeat (3) @(posedge pclk);
      ce <= 1'b1;
      can_engine_model_i.lag = $urandom_range(3);
      wait (can_engine_model_i.ends == 4);
      foreach (ord[i]) chk({3'h0, can_engine_model_i.q[i].id}, {3'h0, idk(ord[i])});
      chk(can_engine_model_i.q[1].data[31:0], dat[2]);
      ctl(2, 32'h2888);
      // receive: overrun, masked twin, stray
      cfg(3, 32'h0, 1'b0, 32'h488);
      cfg(4, 32'hdfe00000, 1'b0, 32'h1488);
      can_engine_model_i.rx_frame({idk(3), 2'b00, 4'h4}, {dat[1], dat[0]});
      can_engine_model_i.rx_frame({idk(3) | 29'h5, 2'b00, 4'h4}, {dat[3], dat[2]});
      can_engine_model_i.rx_frame({idk(31), 2'b00, 4'h4}, {dat[5], dat[4]});
      ctl(3, 32'he484);
      rdk(`OFS_ARBITRATION_WORD_ONE, {3'h0, idk(3)});
      rdk(`OFS_DATA_A_WORDS, dat[2]);
      ctl(4, 32'h1488);
      // remote frames, three transmit setups
      cfg(6, 32'h0, 1'b1, 32'h288);
      cfg(7, 32'h0, 1'b1, 32'h88);
      cfg(8, 32'hdff80000, 1'b1, 32'h1088);
      can_engine_model_i.rx_frame({idk(6), 2'b01, 4'h0}, 64'h0);
      wait (can_engine_model_i.ends == 5);
      chk(can_engine_model_i.q[4].data[31:0], dat[6]);
      chk({31'h0, can_engine_model_i.q[4].rtr}, 32'h0);
      can_engine_model_i.rx_frame({idk(7), 2'b01, 4'h0}, 64'h0);
      ctl(7, 32'h88);
      can_engine_model_i.rx_frame({idk(8) ^ 29'h40000, 2'b01, 4'h3}, 64'h0);
      ctl(8, 32'h9083);
      rdk(`OFS_ARBITRATION_WORD_ONE, {3'h0, idk(8) ^ 29'h40000});
      rdk(`OFS_DATA_A_WORDS, dat[8]);
      chk(can_engine_model_i.ends, 32'h5);
      end_of_test();
   end
endmodule // can_message_object_handler_bench

// ### can_msg_cfg.svh
/*
 * register offsets, command bits and field positions of the message handler.
 * assumes: included by bare name wherever the handler needs a constant.
 */
`ifndef CAN_MSG_CFG_SVH
`define CAN_MSG_CFG_SVH
// ==================================================
// register byte offsets
`define OFS_COMMAND_REQUEST      8'h00
`define OFS_COMMAND_MASK         8'h04
`define OFS_MASK_WORDS           8'h08
`define OFS_ARBITRATION_WORD_ONE 8'h0c
`define OFS_ARBITRATION_WORD_TWO 8'h10
`define OFS_OBJECT_CONTROL_WORD  8'h14
`define OFS_DATA_A_WORDS         8'h18
`define OFS_DATA_B_WORDS         8'h1c
`define OFS_HANDLER_STATUS       8'h20
// ==================================================
// command mask bits
`define CMD_WRITE_DIRECTION      7
`define CMD_MASK                 6
`define CMD_ARB                  5
`define CMD_CONTROL              4
`define CMD_CLEAR_IRQ            3
`define CMD_NEW_DATA             2
`define CMD_DATA_LOW             1
`define CMD_DATA_HIGH            0
// ==================================================
// control word bits, dlc in 3:0
`define CTL_NEW_DATA             15
`define CTL_MSG_LOST             14
`define CTL_IRQ_PENDING          13
`define CTL_USE_MASK             12
`define CTL_TX_IRQ_EN            11
`define CTL_RX_IRQ_EN            10
`define CTL_REMOTE_EN            9
`define CTL_TX_REQUEST           8
`define CTL_END_OF_BLOCK         7
// standard identifier field, command request busy bit
`define STD_ID_LSB               18
`define BUSY_BIT                 15
`endif

// ### can_msg_pkg.sv
/*
 * types of the message handler: object record, frames, scan states.
 * assumes: compiled before the handler module.
 */
package can_msg_pkg;
   // one message object as held in the store
   typedef struct packed {
      logic        object_valid;
      logic        end_of_block;
      logic        direction_transmit;
      logic        xtd;
      logic        mask_extended_flag;
      logic        mask_direction;
      logic        use_acceptance_mask;
      logic        new_data_flag;
      logic        message_lost_flag;
      logic        receive_irq_enable;
      logic        transmit_irq_enable;
      logic        irq_pending;
      logic        remote_enable;
      logic        transmit_request;
      logic [28:0] id;
      logic [28:0] id_mask_bits;
      logic [3:0]  dlc;
      logic [63:0] data;
   } obj_t;
   // header of an incoming frame
   typedef struct packed {
      logic [28:0] id;
      logic        xtd;
      logic        rtr;
      logic [3:0]  dlc;
   } rx_hdr_t;
   // frame offered to the transmit shift register
   typedef struct packed {
      logic [28:0] id;
      logic        xtd;
      logic        rtr;
      logic [3:0]  dlc;
      logic [63:0] data;
   } tx_frame_t;
   // acceptance scan states, gray along idle-scan-match
   typedef enum logic [1:0] {
      SCAN_IDLE  = 2'b00,
      SCAN_WALK  = 2'b01,
      SCAN_MATCH = 2'b11
   } scan_state_t;
endpackage

// ### can_msg_sva.sv
/* checker on handler ports: apb answer, tx handshake, clock enable.
   assumes: bound into every handler, one pclk domain. */
`timescale 1ns/1ps
module can_msg_sva
   import can_msg_pkg::*;
#(
   parameter int NUM_OBJ = 32  // objects in the store
)(
   // clock, reset, enable
   input wire logic        pclk, presetn, ce,
   // apb
   input wire logic        psel, penable, pready, pslverr,
   input wire logic [7:0]  paddr,
   // protocol engine
   input wire logic        tx_ready, tx_valid, tx_ok, tx_fail,
   input wire tx_frame_t   tx_frame
);
   // ==========
   // frame taken, not yet ended
   logic in_flight;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) in_flight <= 1'b0;
      else if (ce && tx_valid && tx_ready) in_flight <= 1'b1;
      else if (ce && (tx_ok || tx_fail)) in_flight <= 1'b0;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   pready_high_a: assert property (pready) else $error("pready low");
   err_unmapped_a: assert property (psel && penable && paddr > 8'h20 |-> pslverr)
      else $error("unmapped, no error");
   err_idle_a: assert property (!(psel && penable) |-> !pslverr) else $error("stray error");
   tx_hold_a: assert property (ce && tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
      else $error("offered frame withdrawn");
   tx_release_a: assert property (ce && tx_valid && tx_ready |=> !tx_valid)
      else $error("frame offered twice");
   ce_freeze_a: assert property (!ce |=> $stable(tx_valid) && $stable(tx_frame))
      else $error("state moved while disabled");
   single_frame_a: assert property (in_flight |-> !tx_valid)
      else $error("load while a frame is active");
   reset_idle_a: assert property ($rose(presetn) |-> !tx_valid) else $error("offer after reset");
   cover property (tx_valid && tx_ready);
   cover property (in_flight && tx_fail);
   cover property (psel && penable && pslverr);
endmodule // can_msg_sva
bind can_message_object_handler can_msg_sva #(.NUM_OBJ(NUM_OBJ)) can_msg_sva_i (.*);
